/* design/async_serial_rx_cfg.svh */
// Purpose: Offsets, field positions, reset values and counts of the receiver.
// Assumes: Avalon-MM byte addresses, one 32-bit word per register.
// Notes:   Definitions only; included by bare name.
`ifndef ASYNC_SERIAL_RX_CFG_SVH
`define ASYNC_SERIAL_RX_CFG_SVH

// ==========================================================================
// Register offsets
`define OFS_MODE      5'h00
`define OFS_DIV       5'h04
`define OFS_LINE      5'h08
`define OFS_STAT      5'h0C
`define OFS_DATA      5'h10

// ==========================================================================
// Field positions
`define MODE_RXEN     0
`define MODE_SYNC     1
`define MODE_SC       2
`define MODE_OVER     3
`define MODE_CHAR_LENGTH_LO  4
`define MODE_CHAR_LENGTH_HI  5
`define MODE_NINE     6
`define MODE_HIGH_BIT_FIRST     7
`define MODE_PAR_LO   8
`define MODE_PAR_HI   10
`define STAT_OVR      8
`define DATA_VALID    31

// ==========================================================================
// Reset values
`define MODE_RST      11'h000
`define DIV_RST       16'h0000
`define RATIO_RST     11'h010
`define DRIFT_RST     1'b0

// ==========================================================================
// Oversampling ratios and drift windows, in oversampling ticks
`define OS_X16        12'h010
`define OS_X8         12'h008
`define OS_X1         12'h001
`define OS_MIN_SC     12'h002
`define EARLY_LO      12'h003
`define EARLY_HI      12'h005
`define JIT_LO        12'h006
`define JIT_HI        12'h008
`define LATE_LO       12'h009
`define LATE_HI       12'h00A

// ==========================================================================
// Parity encodings
`define PAR_EVEN      3'h0
`define PAR_ODD       3'h1
`define PAR_SPACE     3'h2
`define PAR_MARK      3'h3

// ==========================================================================
// Receive buffer shape
`define FIFO_WIDTH    11
`define FIFO_DEPTH    8

`endif

/* design/async_serial_pkg.sv */
// Purpose: Types shared by the receiver files.
// Assumes: Nothing beyond the configuration header.
// Notes:   Types only; all numbers live in the header.
package async_serial_pkg;

  // ========================================================================
  // Receiver states
  typedef enum logic [1:0] {
    RX_IDLE   = 2'b00,
    RX_DATA   = 2'b01,
    RX_PARITY = 2'b10,
    RX_STOP   = 2'b11
  } rx_state_t;

  // ========================================================================
  // Bit period correction
  typedef enum logic [1:0] {
    ADJ_NONE  = 2'b00,
    ADJ_SHORT = 2'b01,
    ADJ_LONG  = 2'b10
  } adj_t;

endpackage

/* design/serial_fifo.sv */
// Purpose: Flip-flop FIFO with valid and ready on both sides.
// Assumes: One clock, asynchronous active-high reset.
// Notes:   Simultaneous push and pop on a full FIFO is refused at the push.
`timescale 1ns/1ps
module serial_fifo #(
  parameter int WIDTH = 11,
  parameter int DEPTH = 8
) (
  input  wire logic                     clk_in,
  input  wire logic                     rst_in,
  input  wire logic                     in_valid_in,
  input  wire logic [WIDTH-1:0]         in_data_in,
  output logic                          in_ready_out,
  output logic                          out_valid_out,
  output logic [WIDTH-1:0]              out_data_out,
  input  wire logic                     out_ready_in,
  output logic [$clog2(DEPTH):0]        count_out
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0]    wr_ptr_ff;
  logic [AW-1:0]    rd_ptr_ff;
  logic [AW:0]      count_ff;
  logic             push;
  logic             pop;

  // Full and empty come straight from the occupancy count.
  assign in_ready_out  = (count_ff != DEPTH[AW:0]);
  assign out_valid_out = (count_ff != '0);
  assign out_data_out  = mem_ff[rd_ptr_ff];
  assign count_out     = count_ff;
  assign push          = in_valid_in & in_ready_out;
  assign pop           = out_ready_in & out_valid_out;

  // Storage is written only on an accepted push.
  always_ff @(posedge clk_in) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= in_data_in;
    end
  end

  // Pointers wrap at the depth, which is a power of two.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff  <= '0;
    end else begin
      if (push) wr_ptr_ff <= wr_ptr_ff + 1'b1;
      if (pop) rd_ptr_ff <= rd_ptr_ff + 1'b1;
      if (push && !pop) count_ff <= count_ff + 1'b1;
      else if (pop && !push) count_ff <= count_ff - 1'b1;
    end
  end
endmodule

/* design/async_serial_receiver_drift.sv */
// Purpose: Oversampling serial receiver with bit drift correction.
// Assumes: rx_in is synchronous to clk_in; Avalon-MM slave, byte addresses.
// Notes:   Characters land in an 8-word FIFO; a full FIFO drops them.
// Operation
// - Drift correction works only with 16x asynchronous oversampling.
// - Drift correction works only while software has set its enable bit.
// - An edge within one tick of where it is expected changes nothing.
// - An edge four to two ticks early shortens the current bit by one tick.
// - An edge two to three ticks late lengthens the current bit by one tick.
// - Asynchronous mode oversamples the line 16 or 8 times per bit.
// - A start is a half-bit of low, then each later bit is sampled in turn.
// - At 16x a start is the eighth low sample and a bit is 16 ticks.
// - At 8x a start is the fourth low sample and a bit is 8 ticks.
// - Length, ninth bit, bit order and parity come from the mode fields.
// - A divisor of zero stops the baud clock and all sampling.
// - Other divisors give clock over divisor times 16, 8, 1 or card ratio.
//
// Local design decisions: the Avalon-MM slave port and the address map.
`timescale 1ns/1ps
`include "async_serial_rx_cfg.svh"
module async_serial_receiver_drift (
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic [4:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  input  wire logic [3:0]  avs_byteenable_in,
  output logic [31:0]      avs_readdata_out,
  output logic             avs_waitrequest_out,
  input  wire logic        rx_in,
  output logic             rx_busy_out
);
  // ========================================================================
  // Declarations
  logic [10:0]                 mode_ff;
  logic [15:0]                 baud_divisor_ff;
  logic [10:0]                 smartcard_rate_ratio_ff;
  logic                        drift_enable_ff;
  logic                        overrun_ff;
  logic                        resp_ff;
  logic [31:0]                 rdata_ff;
  logic [15:0]                 div_cnt_ff;
  logic                        os_tick_ff;
  async_serial_pkg::rx_state_t state_ff;
  async_serial_pkg::adj_t      adj_ff;
  logic [11:0]                 phase_ff;
  logic [11:0]                 low_cnt_ff;
  logic [3:0]                  bit_idx_ff;
  logic [8:0]                  data_ff;
  logic                        par_acc_ff;
  logic                        par_err_ff;
  logic                        rx_prev_ff;
  logic                        push_ff;
  logic [10:0]                 push_data_ff;
  logic                        req;
  logic                        acc;
  logic                        wr_acc;
  logic                        rd_acc;
  logic [31:0]                 rd_word;
  logic [31:0]                 merged;
  logic                        rx_enable;
  logic                        sync_mode;
  logic                        smartcard_mode;
  logic                        over_sel;
  logic [1:0]                  char_length;
  logic                        ninth_bit_enable;
  logic                        high_bit_first;
  logic [2:0]                  parity_type;
  logic [11:0]                 n_os;
  logic [11:0]                 start_need;
  logic [11:0]                 last_phase;
  logic [3:0]                  nbits;
  logic [3:0]                  bit_pos;
  logic                        drift_on;
  logic                        sample;
  logic                        edge_hit;
  logic                        stop_done;
  logic                        par_exp;
  logic                        fifo_in_ready;
  logic                        fifo_out_valid;
  logic [10:0]                 fifo_out_data;
  logic [3:0]                  fifo_count;

  // ========================================================================
  // Functions

  // Oversampling ticks per bit for the current mode.
  function automatic logic [11:0] os_ratio(input logic        sync,
                                           input logic        sc,
                                           input logic        over,
                                           input logic [10:0] ratio);
    if (sc) begin
      os_ratio = (ratio < 11'h002) ? `OS_MIN_SC : {1'b0, ratio};
    end else if (sync) begin
      os_ratio = `OS_X1;
    end else if (over) begin
      os_ratio = `OS_X8;
    end else begin
      os_ratio = `OS_X16;
    end
  endfunction

  // Number of data bits per character.
  function automatic logic [3:0] data_bits(input logic [1:0] len,
                                           input logic       nine);
    data_bits = nine ? 4'h9 : (4'h5 + {2'b00, len});
  endfunction

  // Byte-lane merge of a write into the current register word.
  function automatic logic [31:0] apply_be(input logic [31:0] old,
                                           input logic [31:0] wdat,
                                           input logic [3:0]  be);
    apply_be = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) apply_be[i*8 +: 8] = wdat[i*8 +: 8];
    end
  endfunction

  // ========================================================================
  // Mode decode
  assign rx_enable        = mode_ff[`MODE_RXEN];
  assign sync_mode        = mode_ff[`MODE_SYNC];
  assign smartcard_mode   = mode_ff[`MODE_SC];
  assign over_sel         = mode_ff[`MODE_OVER];
  assign char_length      = mode_ff[`MODE_CHAR_LENGTH_HI:`MODE_CHAR_LENGTH_LO];
  assign ninth_bit_enable = mode_ff[`MODE_NINE];
  assign high_bit_first   = mode_ff[`MODE_HIGH_BIT_FIRST];
  assign parity_type      = mode_ff[`MODE_PAR_HI:`MODE_PAR_LO];
  assign n_os             = os_ratio(sync_mode, smartcard_mode, over_sel,
                                     smartcard_rate_ratio_ff);
  assign start_need       = (n_os < 12'h002) ? 12'h001 : (n_os >> 1);
  assign nbits            = data_bits(char_length, ninth_bit_enable);
  assign bit_pos          = high_bit_first ? (nbits - 4'h1 - bit_idx_ff)
                                           : bit_idx_ff;
  assign drift_on         = drift_enable_ff & ~sync_mode
                            & ~smartcard_mode & ~over_sel;
  assign rx_busy_out      = (state_ff != async_serial_pkg::RX_IDLE);

  // ========================================================================
  // Avalon slave: one wait state, then the answer.
  // A request always sees one waitrequest cycle, so read data can be
  // registered before the master samples it.
  assign req                 = avs_read_in | avs_write_in;
  assign acc                 = req & resp_ff;
  assign wr_acc              = acc & avs_write_in;
  assign rd_acc              = acc & avs_read_in;
  assign avs_waitrequest_out = req & ~resp_ff;
  assign avs_readdata_out    = rdata_ff;
  assign merged = apply_be(rd_word, avs_writedata_in, avs_byteenable_in);

  // Read-back of every register; unmapped offsets read as zero.
  always_comb begin
    case (avs_address_in)
      `OFS_MODE: rd_word = {21'h000000, mode_ff};
      `OFS_DIV:  rd_word = {5'h00, smartcard_rate_ratio_ff, baud_divisor_ff};
      `OFS_LINE: rd_word = {31'h00000000, drift_enable_ff};
      `OFS_STAT: rd_word = {22'h000000, rx_busy_out, overrun_ff,
                            4'h0, fifo_count};
      `OFS_DATA: rd_word = {fifo_out_valid, 20'h00000, fifo_out_data};
      default:   rd_word = 32'h00000000;
    endcase
  end

  // Response timing and registered read data.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      resp_ff  <= 1'b0;
      rdata_ff <= 32'h00000000;
    end else begin
      resp_ff <= req & ~resp_ff;
      if (req && !resp_ff) rdata_ff <= rd_word;
    end
  end

  // Configuration registers, written at the accepting edge only.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      mode_ff                 <= `MODE_RST;
      baud_divisor_ff         <= `DIV_RST;
      smartcard_rate_ratio_ff <= `RATIO_RST;
      drift_enable_ff         <= `DRIFT_RST;
    end else if (wr_acc) begin
      case (avs_address_in)
        `OFS_MODE: mode_ff <= merged[10:0];
        `OFS_DIV: begin
          baud_divisor_ff         <= merged[15:0];
          smartcard_rate_ratio_ff <= merged[26:16];
        end
        `OFS_LINE: drift_enable_ff <= merged[0];
        default: ;
      endcase
    end
  end

  // Overrun flag: a dropped character wins over a clear in the same cycle.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      overrun_ff <= 1'b0;
    end else if (stop_done && !fifo_in_ready) begin
      overrun_ff <= 1'b1;
    end else if (wr_acc && avs_address_in == `OFS_STAT &&
                 avs_byteenable_in[1] && avs_writedata_in[`STAT_OVR]) begin
      overrun_ff <= 1'b0;
    end
  end

  // ========================================================================
  // Baud divider: one oversampling tick every baud_divisor clocks.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      div_cnt_ff <= 16'h0000;
      os_tick_ff <= 1'b0;
    end else if (baud_divisor_ff == 16'h0000) begin
      div_cnt_ff <= 16'h0000;
      os_tick_ff <= 1'b0;
    end else if (div_cnt_ff >= baud_divisor_ff - 16'h0001) begin
      div_cnt_ff <= 16'h0000;
      os_tick_ff <= 1'b1;
    end else begin
      div_cnt_ff <= div_cnt_ff + 16'h0001;
      os_tick_ff <= 1'b0;
    end
  end

  // ========================================================================
  // Bit timing and drift correction.
  // The expected edge lies half a bit after each sampling point.
  always_comb begin
    case (adj_ff)
      async_serial_pkg::ADJ_SHORT: last_phase = n_os - 12'h002;
      async_serial_pkg::ADJ_LONG:  last_phase = n_os;
      default:                     last_phase = n_os - 12'h001;
    endcase
  end

  assign sample    = os_tick_ff & rx_busy_out & (phase_ff == last_phase);
  assign edge_hit  = os_tick_ff & rx_busy_out & (rx_in != rx_prev_ff);
  assign stop_done = sample & (state_ff == async_serial_pkg::RX_STOP);

  // Only one correction per bit; it is dropped at each sampling point.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      adj_ff <= async_serial_pkg::ADJ_NONE;
    end else if (sample || !rx_busy_out || !drift_on) begin
      adj_ff <= async_serial_pkg::ADJ_NONE;
    end else if (edge_hit && adj_ff == async_serial_pkg::ADJ_NONE) begin
      if (phase_ff >= `EARLY_LO && phase_ff <= `EARLY_HI) begin
        adj_ff <= async_serial_pkg::ADJ_SHORT;
      end else if (phase_ff >= `LATE_LO && phase_ff <= `LATE_HI) begin
        adj_ff <= async_serial_pkg::ADJ_LONG;
      end
    end
  end

  // Previous line level, taken on each oversampling tick.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rx_prev_ff <= 1'b1;
    end else if (os_tick_ff) begin
      rx_prev_ff <= rx_in;
    end
  end

  // ========================================================================
  // Character state machine.
  always_comb begin
    case (parity_type)
      `PAR_EVEN:  par_exp = par_acc_ff;
      `PAR_ODD:   par_exp = ~par_acc_ff;
      `PAR_SPACE: par_exp = 1'b0;
      `PAR_MARK:  par_exp = 1'b1;
      default:    par_exp = 1'b0;
    endcase
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_ff   <= async_serial_pkg::RX_IDLE;
      phase_ff   <= 12'h000;
      low_cnt_ff <= 12'h000;
      bit_idx_ff <= 4'h0;
      data_ff    <= 9'h000;
      par_acc_ff <= 1'b0;
      par_err_ff <= 1'b0;
    end else if (!rx_enable) begin
      state_ff   <= async_serial_pkg::RX_IDLE;
      low_cnt_ff <= 12'h000;
    end else if (os_tick_ff) begin
      phase_ff <= (phase_ff == last_phase) ? 12'h000 : phase_ff + 12'h001;
      case (state_ff)
        async_serial_pkg::RX_IDLE: begin
          phase_ff <= 12'h000;
          if (rx_in) begin
            low_cnt_ff <= 12'h000;
          end else if (low_cnt_ff == start_need - 12'h001) begin
            state_ff   <= async_serial_pkg::RX_DATA;
            low_cnt_ff <= 12'h000;
            bit_idx_ff <= 4'h0;
            data_ff    <= 9'h000;
            par_acc_ff <= 1'b0;
            par_err_ff <= 1'b0;
          end else begin
            low_cnt_ff <= low_cnt_ff + 12'h001;
          end
        end
        async_serial_pkg::RX_DATA: begin
          if (sample) begin
            data_ff[bit_pos] <= rx_in;
            par_acc_ff       <= par_acc_ff ^ rx_in;
            bit_idx_ff       <= bit_idx_ff + 4'h1;
            if (bit_idx_ff == nbits - 4'h1) begin
              state_ff <= parity_type[2] ? async_serial_pkg::RX_STOP
                                         : async_serial_pkg::RX_PARITY;
            end
          end
        end
        async_serial_pkg::RX_PARITY: begin
          if (sample) begin
            par_err_ff <= (rx_in != par_exp);
            state_ff   <= async_serial_pkg::RX_STOP;
          end
        end
        async_serial_pkg::RX_STOP: begin
          if (sample) state_ff <= async_serial_pkg::RX_IDLE;
        end
        default: state_ff <= async_serial_pkg::RX_IDLE;
      endcase
    end
  end

  // Finished character into the FIFO; framing error is a low stop bit.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      push_ff      <= 1'b0;
      push_data_ff <= 11'h000;
    end else begin
      push_ff <= stop_done & fifo_in_ready;
      if (stop_done) push_data_ff <= {~rx_in, par_err_ff, data_ff};
    end
  end

  // ========================================================================
  // Receive buffer; a read of the data register pops a valid word.
  serial_fifo #(
    .WIDTH (`FIFO_WIDTH),
    .DEPTH (`FIFO_DEPTH)
  ) u_fifo (
    .clk_in        (clk_in),
    .rst_in        (rst_in),
    .in_valid_in   (push_ff),
    .in_data_in    (push_data_ff),
    .in_ready_out  (fifo_in_ready),
    .out_valid_out (fifo_out_valid),
    .out_data_out  (fifo_out_data),
    .out_ready_in  (rd_acc && avs_address_in == `OFS_DATA &&
                    rdata_ff[`DATA_VALID]),
    .count_out     (fifo_count)
  );

  // ========================================================================
  // Assertions
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  sequence s_early;
    edge_hit && drift_on && !sample &&
    adj_ff == async_serial_pkg::ADJ_NONE &&
    phase_ff >= `EARLY_LO && phase_ff <= `EARLY_HI;
  endsequence

  sequence s_late;
    edge_hit && drift_on && !sample &&
    adj_ff == async_serial_pkg::ADJ_NONE &&
    phase_ff >= `LATE_LO && phase_ff <= `LATE_HI;
  endsequence

  property p_drift_gate;
    adj_ff != async_serial_pkg::ADJ_NONE |-> $past(drift_on);
  endproperty
  a_drift_gate: assert property (p_drift_gate)
    else $error("Bit period corrected while drift correction is off.");

  property p_jitter;
    edge_hit && !sample && adj_ff == async_serial_pkg::ADJ_NONE &&
    phase_ff >= `JIT_LO && phase_ff <= `JIT_HI
    |=> adj_ff == async_serial_pkg::ADJ_NONE;
  endproperty
  a_jitter: assert property (p_jitter)
    else $error("Jitter edge changed the bit period.");

  property p_short;
    s_early |=> adj_ff == async_serial_pkg::ADJ_SHORT;
  endproperty
  a_short: assert property (p_short)
    else $error("Early edge did not shorten the bit.");

  property p_long;
    s_late |=> adj_ff == async_serial_pkg::ADJ_LONG;
  endproperty
  a_long: assert property (p_long)
    else $error("Late edge did not lengthen the bit.");

  property p_div_zero;
    (baud_divisor_ff == 16'h0000)[*2] |-> !os_tick_ff && !sample;
  endproperty
  a_div_zero: assert property (p_div_zero)
    else $error("Tick seen with a zero divisor.");

  property p_tick_gap;
    disable iff (rst_in || wr_acc)
    os_tick_ff && baud_divisor_ff == 16'h0003
    |=> (!os_tick_ff)[*2] ##1 os_tick_ff;
  endproperty
  a_tick_gap: assert property (p_tick_gap)
    else $error("Tick spacing differs from the divisor.");

  property p_start;
    state_ff == async_serial_pkg::RX_IDLE ##1
    state_ff == async_serial_pkg::RX_DATA
    |-> $past(low_cnt_ff) == $past(start_need) - 12'h001 && !$past(rx_in);
  endproperty
  a_start: assert property (p_start)
    else $error("Start declared on the wrong low sample.");

  property p_bit16;
    disable iff (rst_in || wr_acc)
    sample && state_ff == async_serial_pkg::RX_DATA &&
    bit_idx_ff == 4'h0 && baud_divisor_ff == 16'h0001 &&
    n_os == `OS_X16 && !drift_on
    |=> (!sample)[*8] ##1 (!sample)[*7] ##1 sample;
  endproperty
  a_bit16: assert property (p_bit16)
    else $error("A 16x bit did not last 16 ticks.");

  property p_nbits;
    state_ff == async_serial_pkg::RX_DATA ##1
    state_ff != async_serial_pkg::RX_DATA && rx_enable
    |-> $past(bit_idx_ff) == $past(nbits) - 4'h1;
  endproperty
  a_nbits: assert property (p_nbits)
    else $error("Character length differs from the mode field.");

  property p_stop_idle;
    stop_done && rx_enable |=> state_ff == async_serial_pkg::RX_IDLE;
  endproperty
  a_stop_idle: assert property (p_stop_idle)
    else $error("Receiver did not go idle after the stop bit.");
endmodule

/* sim/serial_tx_model.sv */
// Purpose: Remote serial transmitter that drives the receive line.
// Assumes: One oversampling tick per clock times the period handed in.
// Notes:   Sends start, eight data bits low first, then stop.
`timescale 1ns/1ps
module serial_tx_model (
  input  wire logic clk_in,
  output logic      line_out
);
  // The line idles high between frames, as a pulled-up line would.
  initial line_out = 1'b1;
  // =======================================================================
  // Frame sender.
  task automatic send(input logic [7:0] b, input int n);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clk_in);
      line_out <= f[i];
      repeat (n - 1) @(posedge clk_in);
    end
    repeat (n) @(posedge clk_in);
  endtask
endmodule

/* sim/tb_async_serial_receiver_drift.sv */
// Purpose: Self-checking bench for the drift-correcting receiver.
// Assumes: Eight data bits, no parity, bus answers after one wait cycle.
// Notes:   Expected words of the fill test come from a queue model of the receive FIFO.
`timescale 1ns/1ps
`include "async_serial_rx_cfg.svh"
module tb_async_serial_receiver_drift;
  logic        clk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic        wrq;
  logic        line;
  logic        busy;
  logic [4:0]  adr = 5'h00;
  logic [31:0] wd = 32'h0;
  logic [31:0] rdat;
  logic [31:0] q;
  logic [7:0]  b;
  logic [7:0]  r;
  logic [7:0]  exp_q[$];
  int          failures = 0;
  int          checks_done = 0;
  int          cyc = 0;
  always #10 clk_in = ~clk_in;
  async_serial_receiver_drift dut_u (.clk_in(clk_in), .rst_in(rst_in),
    .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr),
    .avs_writedata_in(wd), .avs_byteenable_in(4'hF),
    .avs_readdata_out(rdat), .avs_waitrequest_out(wrq), .rx_in(line),
    .rx_busy_out(busy));
  serial_tx_model tx_u (.clk_in(clk_in), .line_out(line));
  // =======================================================================
  // Bus cycle; waitrequest and read data are both taken at a rising edge.
  // The leading edge keeps two calls from driving a strobe twice at once.
  task automatic bus(input logic w, input logic [4:0] a, input int d);
    @(posedge clk_in);
    adr <= a;
    wd <= d;
    rd <= !w;
    wr <= w;
    @(posedge clk_in);
    while (wrq !== 1'b0) @(posedge clk_in);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic chk(string n, logic [31:0] e, logic [31:0] s);
    checks_done++;
    if (s !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // A hung handshake or receiver is cut short here.
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 40000) begin
      failures++;
      give_verdict();
    end
  end
  initial begin
    void'($urandom(32'h980B));
    repeat (10) @(posedge clk_in);
    rst_in <= 1'b0;
    // Every mix of ratio, bit order and divisor.
    for (int i = 0; i < 8; i++) begin
      b = 8'($urandom);
      r = {<<{b}};
      bus(1, `OFS_DIV, 1 + 2 * i[2]);
      bus(1, `OFS_MODE, 32'h431 | (i[0] * 8) | (i[1] * 128));
      // The busy pin is looked at well inside the frame.
      fork
        tx_u.send(b, (1 + 2 * i[2]) * (i[0] ? 8 : 16));
        begin
          repeat (40) @(posedge clk_in);
          chk("busy", 32'h1, {31'h0, busy});
        end
      join
      bus(0, `OFS_DATA, 0);
      chk("data", {1'b1, 23'h000000, i[1] ? r : b}, q);
      $display("format %0d done", i);
    end
    // Fast sender: only the enabled correction keeps the last bit.
    bus(1, `OFS_DIV, 1);
    bus(1, `OFS_MODE, 32'h431);
    for (int d = 0; d < 2; d++) begin
      bus(1, `OFS_LINE, d);
      tx_u.send(8'h55, 15);
      bus(0, `OFS_DATA, 0);
      chk("drift", d ? 32'h80000055 : 32'h800000D5, q);
    end
    $display("drift done");
    bus(1, `OFS_DIV, 0);
    tx_u.send(8'hA5, 16);
    bus(0, `OFS_STAT, 0);
    chk("stopped", 32'h0, q & 32'h30F);
    $display("divisor zero done");
    // Nine back-to-back frames into eight words: one is dropped.
    bus(1, `OFS_DIV, 1);
    bus(1, `OFS_MODE, 32'h439);
    for (int i = 0; i < 9; i++) begin
      b = 8'($urandom);
      if (i < 8) exp_q.push_back(b);
      tx_u.send(b, 8);
    end
    bus(0, `OFS_STAT, 0);
    chk("full", 32'h108, q & 32'h30F);
    while (exp_q.size() > 0) begin
      bus(0, `OFS_DATA, 0);
      chk("drain", {24'h800000, exp_q.pop_front()}, q);
    end
    bus(0, `OFS_DATA, 0);
    chk("empty", 32'h0, q & 32'h80000000);
    $display("fill done");
    give_verdict();
  end
endmodule
